// [rtl/ure_pkg.sv]
// Contract
// R1: bits 7:4 of register downstream_rx_eq_select hold the level used by the second downstream receiver.
// R2: bits 3:0 of register downstream_rx_eq_select hold the level used by the first downstream receiver.
// R3: with override clear, each level field reads back the value sampled from its pins.
// R4: with override set, a software write to a level field changes the level applied by its receiver.
// R5: bits 3:0 of register upstream_rx_eq_select select the upstream receiver level, bits 7:4 are reserved read-only.
// R6: bit 7 of register link_power_compliance_ctrl is a hardware flag, 1 while in compliance mode.
// R7: bit 6 of register link_power_compliance_ctrl clear forces level zero during lfps, set applies the selected levels.
// R8: bit 5 of register link_power_compliance_ctrl set demands lfps persist 200us before low power exit, clear exits at once.
// R9: bit 4 of register link_power_compliance_ctrl set stops receiver detection in u2 and u3.
// R10: bits 3:2 of register link_power_compliance_ctrl choose the detect interval, 00 is 8 ms and 01 is 12 ms, others reserved.
// R11: compliance code 00 leaves entry to the link state machine, code 11 never enters.
// R12: compliance code 01 forces the upstream to downstream direction, code 10 the reverse one.
// R13: registers downstream_rx_eq_select, upstream_rx_eq_select and link_power_compliance_ctrl reset to all zeros.
// R14: software sets the override bit before writing level values it wants applied.
// R15: reserved bits read zero and writes to them or to read-only bits are ignored.
package ure_pkg;
  localparam logic [7:0] ADDR_DOWN_EQ = 8'h20;
  localparam logic [7:0] ADDR_UP_EQ = 8'h21;
  localparam logic [7:0] ADDR_LINK_CTRL = 8'h22;
  localparam logic [7:0] RESET_VALUE = 8'h00;
  localparam int SECOND_LSB = 4;
  localparam int FIRST_LSB = 0;
  localparam int UP_LSB = 0;
  localparam int CM_BIT = 7;
  localparam int LFPS_APPLY_BIT = 6;
  localparam int DEBOUNCE_BIT = 5;
  localparam int DETECT_OFF_BIT = 4;
  localparam int PERIOD_LSB = 2;
  localparam int FORCE_LSB = 0;
  localparam logic [7:0] LINK_WRITE_MASK = 8'h7f;
  localparam logic [7:0] UP_WRITE_MASK = 8'h0f;
  localparam int CLK_HZ = 20000000;
  localparam int DEBOUNCE_US = 200;
  localparam int DEBOUNCE_CYCLES = DEBOUNCE_US * (CLK_HZ / 1000000);
  localparam int PERIOD_8_MS = 8;
  localparam int PERIOD_12_MS = 12;
  localparam int PERIOD_8_CYCLES = PERIOD_8_MS * (CLK_HZ / 1000);
  localparam int PERIOD_12_CYCLES = PERIOD_12_MS * (CLK_HZ / 1000);
  localparam logic [1:0] FORCE_AUTO = 2'h0;
  localparam logic [1:0] FORCE_DOWN_DIR = 2'h1;
  localparam logic [1:0] FORCE_UP_DIR = 2'h2;
  localparam logic [1:0] FORCE_NEVER = 2'h3;

  typedef struct packed {
    logic [3:0] second_rx_level_sel;
    logic [3:0] first_rx_level_sel;
    logic [3:0] upstream_rx_level_sel;
  } ure_levels_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ure_req_t;
endpackage : ure_pkg

// [rtl/ure_lfps_timer.sv]
`timescale 1ns/10ps
module ure_lfps_timer #(
  parameter int unsigned DEBOUNCE = ure_pkg::DEBOUNCE_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic debounce_on,
  input wire logic lfps_seen,
  // result
  output logic exit_ok
);
  import ure_pkg::*;
  logic [31:0] count;
  logic [31:0] next_count;

  // counter restarts on any gap in lfps
  assign next_count = !lfps_seen ? 32'h0 : (count == DEBOUNCE ? count : count + 32'h1);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      count <= 32'h0;
    else
      count <= next_count;
  end

  assign exit_ok = lfps_seen && (!debounce_on || count == DEBOUNCE); // R8
endmodule : ure_lfps_timer

// [rtl/ure_regs.sv]
`timescale 1ns/10ps
module ure_regs #(
  parameter int unsigned DEBOUNCE = ure_pkg::DEBOUNCE_CYCLES,
  parameter int unsigned PERIOD_8 = ure_pkg::PERIOD_8_CYCLES,
  parameter int unsigned PERIOD_12 = ure_pkg::PERIOD_12_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register access from the configuration port
  input wire ure_pkg::ure_req_t req,
  output logic [7:0] rdata,
  // override, software sets it first
  input wire logic soft_level_override,
  // level pins, asynchronous
  input wire logic [1:0] downstream_level_pins,
  input wire logic [1:0] upstream_level_pins,
  // link side, asynchronous
  input wire logic lfps_active,
  input wire logic low_power_state,
  input wire logic fsm_compliance_req,
  // equalizer and link controls
  output ure_pkg::ure_levels_t applied_levels,
  output logic low_power_exit,
  output logic detect_pulse,
  output logic compliance_active_flag,
  output logic force_down_dir,
  output logic force_up_dir
);
  import ure_pkg::*;

  logic [7:0] down_eq;
  logic [7:0] up_eq;
  logic [7:0] link_ctrl;
  logic [1:0] dpin_s1, dpin_s2, upin_s1, upin_s2;
  logic [2:0] link_s1, link_s2;
  logic [31:0] period_count;
  logic [7:0] down_read;
  logic [7:0] up_read;
  logic [7:0] link_read;
  logic [3:0] pin_down_level;
  logic [3:0] pin_up_level;
  logic wr_down, wr_up, wr_link;
  logic lfps_s, lowp_s, fsm_cm_s;
  logic detect_allowed;
  logic [31:0] period_limit;
  logic cm_now;
  ure_levels_t sel_levels;

  // pins are asynchronous straps, double flopped
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      dpin_s1 <= 2'h0;
      dpin_s2 <= 2'h0;
      upin_s1 <= 2'h0;
      upin_s2 <= 2'h0;
      link_s1 <= 3'h0;
      link_s2 <= 3'h0;
    end
    else
    begin
      dpin_s1 <= downstream_level_pins;
      dpin_s2 <= dpin_s1;
      upin_s1 <= upstream_level_pins;
      upin_s2 <= upin_s1;
      link_s1 <= {lfps_active, low_power_state, fsm_compliance_req};
      link_s2 <= link_s1;
    end
  end

  assign lfps_s = link_s2[2];
  assign lowp_s = link_s2[1];
  assign fsm_cm_s = link_s2[0];

  // two pins expand to a four-bit level; spread keeps the step even
  assign pin_down_level = {dpin_s2, dpin_s2};
  assign pin_up_level = {upin_s2, upin_s2};

  assign wr_down = req.wr && req.addr == ADDR_DOWN_EQ;
  assign wr_up = req.wr && req.addr == ADDR_UP_EQ;
  assign wr_link = req.wr && req.addr == ADDR_LINK_CTRL;

  // writes land only while override is set; without it the pins win
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      down_eq <= RESET_VALUE; // R13
    else if (!soft_level_override)
      down_eq <= {pin_down_level, pin_down_level}; // R3
    else if (wr_down)
      down_eq <= req.wdata; // R1 R2 R4
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      up_eq <= RESET_VALUE; // R13
    else if (!soft_level_override)
      up_eq <= {4'h0, pin_up_level}; // R3 R5
    else if (wr_up)
      up_eq <= req.wdata & UP_WRITE_MASK; // R4 R5 R15
  end

  // flag bit is never written from software
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      link_ctrl <= RESET_VALUE; // R13
    else if (wr_link)
      link_ctrl <= req.wdata & LINK_WRITE_MASK; // R15
  end

  // compliance decision
  assign cm_now = (link_ctrl[FORCE_LSB +: 2] == FORCE_AUTO) ? fsm_cm_s : // R11
                  (link_ctrl[FORCE_LSB +: 2] != FORCE_NEVER); // R11 R12
  assign force_down_dir = link_ctrl[FORCE_LSB +: 2] == FORCE_DOWN_DIR; // R12
  assign force_up_dir = link_ctrl[FORCE_LSB +: 2] == FORCE_UP_DIR; // R12

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      compliance_active_flag <= 1'b0;
    else
      compliance_active_flag <= cm_now; // R6
  end

  // read mux, reserved bits come back zero
  assign down_read = down_eq;
  assign up_read = {4'h0, up_eq[UP_LSB +: 4]}; // R15
  assign link_read = {compliance_active_flag, link_ctrl[6:0]}; // R6
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rdata <= 8'h00;
    else if (req.rd)
      rdata <= (req.addr == ADDR_DOWN_EQ) ? down_read :
               (req.addr == ADDR_UP_EQ) ? up_read :
               (req.addr == ADDR_LINK_CTRL) ? link_read : 8'h00;
  end

  // levels applied to the receivers
  assign sel_levels.second_rx_level_sel = down_eq[SECOND_LSB +: 4]; // R1
  assign sel_levels.first_rx_level_sel = down_eq[FIRST_LSB +: 4]; // R2
  assign sel_levels.upstream_rx_level_sel = up_eq[UP_LSB +: 4]; // R5
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      applied_levels <= '0;
    else if (lfps_s && !link_ctrl[LFPS_APPLY_BIT])
      applied_levels <= '0; // R7
    else
      applied_levels <= sel_levels; // R7
  end

  // low power exit with optional debounce
  logic exit_ok;
  ure_lfps_timer #(
    .DEBOUNCE(DEBOUNCE)
  ) u_timer (
    .clk(clk),
    .rst(rst),
    .debounce_on(link_ctrl[DEBOUNCE_BIT]),
    .lfps_seen(lfps_s && lowp_s),
    .exit_ok(exit_ok)
  );
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      low_power_exit <= 1'b0;
    else
      low_power_exit <= exit_ok; // R8
  end

  // receiver detect timer; reserved codes fall back to 12 ms
  assign period_limit = (link_ctrl[PERIOD_LSB +: 2] == 2'h0) ? PERIOD_8 : PERIOD_12; // R10
  assign detect_allowed = !(lowp_s && link_ctrl[DETECT_OFF_BIT]); // R9
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      period_count <= 32'h0;
      detect_pulse <= 1'b0;
    end
    else
    begin
      detect_pulse <= 1'b0;
      if (period_count >= period_limit - 32'h1)
      begin
        period_count <= 32'h0;
        detect_pulse <= detect_allowed; // R9 R10
      end
      else
        period_count <= period_count + 32'h1;
    end
  end
endmodule : ure_regs

// [tb/ure_regs_props.sv]
`timescale 1ns/10ps
module ure_regs_props (
  // watched ports
  input wire logic clk,
  input wire logic rst,
  input wire ure_pkg::ure_req_t req,
  input wire logic [7:0] rdata,
  input wire logic soft_level_override,
  input wire logic [1:0] downstream_level_pins,
  input wire logic lfps_active,
  input wire logic low_power_state,
  input wire ure_pkg::ure_levels_t applied_levels,
  input wire logic detect_pulse,
  input wire logic compliance_active_flag,
  input wire logic force_down_dir,
  input wire logic force_up_dir
);
  import ure_pkg::*;
  logic [6:0] c;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // shadow of control bits, bit 7 is hardware owned
  always_ff @(posedge clk or posedge rst)
    if (rst)
      c <= 7'h00;
    else if (req.wr && req.addr == 8'h22)
      c <= req.wdata[6:0];
  dir_down_a: assert property (force_down_dir == (c[1:0] == 2'h1))
    else $error("down force wrong");
  dir_up_a: assert property (force_up_dir == (c[1:0] == 2'h2))
    else $error("up force wrong");
  never_cm_a: assert property (c[1:0] == 2'h3 ##1 c[1:0] == 2'h3 |-> !compliance_active_flag)
    else $error("flag set while disabled");
  read_ctrl_a: assert property (req.rd && req.addr == 8'h22 |=> rdata == {$past(compliance_active_flag), $past(c)})
    else $error("control readback wrong");
  unmapped_a: assert property (req.rd && !(req.addr inside {[8'h20:8'h22]}) |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  lfps_zero_a: assert property ((lfps_active && !c[6]) [*4] |-> applied_levels == '0)
    else $error("level not zeroed in lfps");
  down_pins_a: assert property ((!soft_level_override && !lfps_active && $stable(downstream_level_pins)) [*6]
    |-> applied_levels[11:4] == {4{downstream_level_pins}})
    else $error("levels do not track pins");
  det_off_a: assert property ((c[4] && low_power_state) [*4] |-> !detect_pulse)
    else $error("detect in low power");
  cover property (compliance_active_flag);
  cover property (req.wr && soft_level_override);
  cover property (c[4] && low_power_state);
endmodule : ure_regs_props

// [tb/ure_host.sv]
`timescale 1ns/10ps
module ure_host (
  // clock
  input wire logic clk,
  // configuration port
  output ure_pkg::ure_req_t req,
  output logic soft_level_override
);
  import ure_pkg::*;
  initial
  begin
    req = '0;
    soft_level_override = 1'b0;
  end
  // one cycle per access, idle cycle between to keep rd and wr apart
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #1 req = '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk) #1 req = '0;
  endtask : acc
  task automatic ovr(input logic v);
    @(posedge clk) #1 soft_level_override = v;
  endtask : ovr
endmodule : ure_host

// [tb/usb_redriver_eq_compliance_regs_test.sv]
`timescale 1ns/10ps
module usb_redriver_eq_compliance_regs_test;
  import ure_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  ure_req_t req;
  ure_levels_t lv;
  logic [7:0] rdata, e, r;
  logic ovr, ex, dp, cm, fd, fu, lf = 0, lp = 0, fq = 0, pend = 0;
  logic [1:0] dpin = 2'h0, upin = 2'h0;
  logic [31:0] s = 32'hc5f3;
  logic [7:0] q[$];
  int n_errors = 0, samples_checked = 0, k, t;
  always #25 clk = ~clk;
  ure_host h (.clk(clk), .req(req), .soft_level_override(ovr));
  // short counts keep the run brief
  ure_regs #(.DEBOUNCE(10), .PERIOD_8(20), .PERIOD_12(30)) DUT (.clk(clk), .rst(rst), .req(req), .rdata(rdata),
    .soft_level_override(ovr), .downstream_level_pins(dpin), .upstream_level_pins(upin), .lfps_active(lf),
    .low_power_state(lp), .fsm_compliance_req(fq), .applied_levels(lv), .low_power_exit(ex), .detect_pulse(dp),
    .compliance_active_flag(cm), .force_down_dir(fd), .force_up_dir(fu));
  task automatic chk(input logic [11:0] a, input logic [11:0] b);
    samples_checked++;
    if (a !== b)
    begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, a, b);
    end
  endtask : chk
  function automatic logic [7:0] rnd();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s[7:0];
  endfunction : rnd
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wt
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    q.push_back(x);
    h.acc(1'b0, a, 8'h00);
  endtask : rd
  task automatic gap(input int p);
    repeat (2)
    begin
      t = 0;
      @(negedge clk);
      while (dp !== 1'b1 && t < 99)
      begin
        @(negedge clk);
        t++;
      end
    end
    chk(t[11:0] + 12'h1, p[11:0]);
  endtask : gap
  task automatic final_report();
    $display("checked %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report
  always @(negedge clk)
  begin
    if (pend)
      chk({4'h0, rdata}, {4'h0, q.pop_front()});
    pend = req.rd;
  end
  initial
  begin
    #400000;
    n_errors++;
    final_report();
  end
  initial
  begin
    repeat (8) @(posedge clk);
    #1 rst = 1'b0;
    rd(8'h20, 8'h00);
    rd(8'h21, 8'h00);
    rd(8'h22, 8'h00);
    dpin = 2'h2;
    upin = 2'h1;
    h.acc(1'b1, 8'h20, 8'h5c);
    wt(4);
    rd(8'h20, 8'haa);
    rd(8'h21, 8'h05);
    $display("end pins");
    h.ovr(1'b1);
    r = rnd();
    e = rnd();
    h.acc(1'b1, 8'h20, r);
    h.acc(1'b1, 8'h21, e);
    rd(8'h20, r);
    rd(8'h21, e & 8'h0f);
    chk(lv, {r, e[3:0]});
    lf = 1'b1;
    wt(5);
    chk(lv, 12'h000);
    h.acc(1'b1, 8'h22, 8'h40);
    wt(3);
    chk(lv, {r, e[3:0]});
    lf = 1'b0;
    $display("end levels");
    for (k = 0; k < 4; k++)
    begin
      h.acc(1'b1, 8'h22, 8'h80 | k[7:0]);
      rd(8'h22, {k == 1 || k == 2, k[6:0]});
      chk({10'h0, fd, fu}, {10'h0, k == 1, k == 2});
      chk({11'h0, cm}, {11'h0, k == 1 || k == 2});
    end
    // code 00 hands the decision to the link state machine
    fq = 1'b1;
    h.acc(1'b1, 8'h22, 8'h00);
    rd(8'h22, 8'h80);
    h.acc(1'b1, 8'h22, 8'h03);
    rd(8'h22, 8'h03);
    fq = 1'b0;
    $display("end compliance");
    lp = 1'b1;
    lf = 1'b1;
    wt(4);
    chk({11'h0, ex}, 12'h001);
    lf = 1'b0;
    h.acc(1'b1, 8'h22, 8'h33);
    wt(4);
    lf = 1'b1;
    wt(6);
    chk({11'h0, ex}, 12'h000);
    wt(10);
    chk({11'h0, ex}, 12'h001);
    lp = 1'b0;
    lf = 1'b0;
    wt(35);
    gap(20);
    h.acc(1'b1, 8'h22, 8'h07);
    wt(35);
    gap(30);
    rd(8'h30, 8'h00);
    wt(3);
    $display("end timing");
    final_report();
  end
endmodule : usb_redriver_eq_compliance_regs_test
bind ure_regs ure_regs_props p (.clk(clk), .rst(rst), .req(req), .rdata(rdata),
  .soft_level_override(soft_level_override), .downstream_level_pins(downstream_level_pins),
  .lfps_active(lfps_active), .low_power_state(low_power_state), .applied_levels(applied_levels),
  .detect_pulse(detect_pulse), .compliance_active_flag(compliance_active_flag),
  .force_down_dir(force_down_dir), .force_up_dir(force_up_dir));
